// >>> include/jrx_pkg.sv
// constants, types and states shared by the register-jump and exchange unit
`default_nettype none
package jrx_pkg;

  localparam int XLEN = 32;

  // compact register-jump format
  localparam logic [4:0] REGISTER_FORMAT_OPCODE = 5'h1D;
  localparam logic [4:0] RJ_FUNCTION = 5'h00;
  localparam int OPC_HI  = 15;
  localparam int OPC_LO  = 11;
  localparam int RX_HI   = 10;
  localparam int RX_LO   = 8;
  localparam int NO_DELAY_BIT = 7;
  localparam int LNK_BIT      = 6;
  localparam int RET_SEL_BIT  = 5;
  localparam int FN_HI   = 4;
  localparam int FN_LO   = 0;
  localparam logic [2:0] RX_RET_ONLY = 3'h0;

  // register translation for the 3-bit source field
  localparam logic [2:0] RX_HIGH_LIMIT = 3'h2;
  localparam logic [3:0] RX_HIGH_BASE  = 4'h8;
  localparam logic [1:0] RX_LOW_BASE   = 2'h0;

  // 32-bit exchange jump format; opcode value is a plain default
  localparam int X_OPC_HI = 31;
  localparam int X_OPC_LO = 26;
  localparam int X_IDX_HI = 25;
  localparam logic [5:0] XJ_OPCODE = 6'h1D;

  localparam logic [4:0]  LINK_REG    = 5'h1F;
  localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
  localparam logic [31:0] SLOT_OFFSET = 32'h0000_0004;
  localparam int REGION_LO = 28;
  localparam logic [1:0] IDX_PAD = 2'h0;
  localparam logic MODE_WIDE    = 1'b0;
  localparam logic MODE_COMPACT = 1'b1;
  localparam logic MODE_RESET   = MODE_WIDE;

  // register map
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_EVENT  = 8'h08;
  localparam logic [AW-1:0] OFS_MASK   = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RESET = 1'b1;
  localparam int EVW = 4;
  localparam int EV_JUMP = 0;
  localparam int EV_XCHG = 1;
  localparam int EV_ADDR = 2;
  localparam int EV_HAZ  = 3;
  localparam logic [EVW-1:0] MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {ST_IDLE, ST_SLOT} core_state_e;

  typedef struct packed {
    logic            valid;
    logic [XLEN-1:0] target;
    logic            mode;
  } redirect_s;

  typedef struct packed {
    logic            en;
    logic [4:0]      idx;
    logic [XLEN-1:0] data;
  } link_s;

endpackage : jrx_pkg

`default_nettype wire

// >>> hw/jump_register_and_exchange_unit.sv
// register-jump and exchange-jump decode with next-pc, link and mode logic
// Notes on behaviour
// RULE_01 - exchange jump links pc plus 8 into 31
// RULE_02 - link bit 0 holds current mode bit
// RULE_03 - target: index shifted 2, upper from slot
// RULE_04 - last-word jump lands in next region
// RULE_05 - exchange jump inverts the mode bit
// RULE_06 - slot instruction runs before pc changes
// RULE_07 - software keeps jumps out of wide slots
// RULE_08 - decode register jumps by opcode, flags, field
// RULE_09 - delayed jump through register 31, no link
// RULE_10 - delayed jump through selected register
// RULE_11 - immediate jump through register 31
// RULE_12 - immediate jump through selected register
// RULE_13 - mode bit loads from source bit 0
// RULE_14 - target bit 0 forced to zero
// RULE_15 - misaligned target faults at fetch time
// RULE_16 - software avoids extended ops in slots
// RULE_17 - software keeps jumps out of compact slots
// RULE_18 - field codes 0,1 map 16,17; else same
`timescale 1ns/1ps
`default_nettype none

module jump_register_and_exchange_unit
  import jrx_pkg::*;
(
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // issue stage
  input  wire logic            issue_valid,
  input  wire logic [XLEN-1:0] issue_word,
  input  wire logic [XLEN-1:0] issue_pc,
  input  wire logic            fetch_valid,
  // register file read port
  output logic      [4:0]      rf_rd_idx,
  input  wire logic [XLEN-1:0] rf_rd_data,
  // results towards pc and register file
  output redirect_s            redirect,
  output link_s                link_wr,
  output logic                 addr_error,
  output logic                 instruction_set_select_bit,
  output logic                 irq,
  // axi4-lite slave
  input  wire logic [AW-1:0]   s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [XLEN-1:0] s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [AW-1:0]   s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [XLEN-1:0]      s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);

  // core state
  core_state_e     st_q, st_d;
  logic [XLEN-1:0] tgt_q, tgt_d;
  logic            tmode_q, tmode_d;
  logic            tmis_q, tmis_d;
  logic            mode_q, mode_d;
  logic            chk_q, chk_d;
  logic            aerr_q, aerr_d;
  redirect_s       redir_q, redir_d;
  link_s           link_q, link_d;
  logic [EVW-1:0]  ev_set;

  // bus state
  logic            ctrl_en_q, ctrl_en_d;
  logic [EVW-1:0]  ev_q, ev_d;
  logic [EVW-1:0]  mask_q, mask_d;
  logic            aw_have_q, aw_have_d;
  logic            w_have_q, w_have_d;
  logic [AW-1:0]   awaddr_q, awaddr_d;
  logic [XLEN-1:0] wdata_q, wdata_d;
  logic            wstrb0_q, wstrb0_d;
  logic            bvalid_q, bvalid_d;
  logic [1:0]      bresp_q, bresp_d;
  logic            rvalid_q, rvalid_d;
  logic [1:0]      rresp_q, rresp_d;
  logic [XLEN-1:0] rdata_q, rdata_d;

  // decode
  logic [15:0]     half;
  logic            reg_jump;
  logic            x_jump;
  logic            any_jump;
  logic            no_delay;
  logic [2:0]      rx;
  logic [XLEN-1:0] slot_pc;
  logic [XLEN-1:0] link_pc;

  assign half = issue_word[15:0];
  assign rx   = half[RX_HI:RX_LO];

  // link-flag forms belong to another unit and are not decoded here
  assign reg_jump = (mode_q == MODE_COMPACT)
                 && (half[OPC_HI:OPC_LO] == REGISTER_FORMAT_OPCODE)
                 && (half[FN_HI:FN_LO] == RJ_FUNCTION)
                 && !half[LNK_BIT]
                 && (!half[RET_SEL_BIT] || rx == RX_RET_ONLY); // RULE_08
  assign x_jump  = (mode_q == MODE_WIDE)
                 && (issue_word[X_OPC_HI:X_OPC_LO] == XJ_OPCODE);
  assign any_jump = issue_valid && ctrl_en_q && (reg_jump || x_jump);
  assign no_delay = reg_jump && half[NO_DELAY_BIT];

  // source register selection and translation
  always_comb begin
    if (half[RET_SEL_BIT]) begin
      rf_rd_idx = LINK_REG; // RULE_09 RULE_11
    end else if (rx < RX_HIGH_LIMIT) begin
      rf_rd_idx = {RX_HIGH_BASE, rx[0]}; // RULE_18
    end else begin
      rf_rd_idx = {RX_LOW_BASE, rx}; // RULE_18
    end
  end

  assign slot_pc = issue_pc + SLOT_OFFSET;
  assign link_pc = issue_pc + LINK_OFFSET; // RULE_01

  always_comb begin
    st_d        = st_q;
    tgt_d       = tgt_q;
    tmode_d     = tmode_q;
    tmis_d      = tmis_q;
    mode_d      = mode_q;
    chk_d       = chk_q;
    aerr_d      = 1'b0;
    redir_d     = '0;
    link_d      = '0;
    ev_set      = '0;
    // the fault belongs to the fetch of the target, not to the jump
    if (chk_q && fetch_valid) begin
      chk_d = 1'b0;
      if (tmis_q) begin
        aerr_d         = 1'b1; // RULE_15
        ev_set[EV_ADDR] = 1'b1;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (any_jump) begin
          ev_set[EV_JUMP] = 1'b1;
          if (x_jump) begin
            ev_set[EV_XCHG] = 1'b1;
            // upper bits from the slot address cover the region edge
            tgt_d = {slot_pc[XLEN-1:REGION_LO],
                     issue_word[X_IDX_HI:0], IDX_PAD}; // RULE_03 RULE_04
            tmode_d = !mode_q; // RULE_05
            tmis_d  = 1'b0;
            link_d.en   = 1'b1;
            link_d.idx  = LINK_REG; // RULE_01
            link_d.data = {link_pc[XLEN-1:1], mode_q}; // RULE_02
          end else begin
            tgt_d   = {rf_rd_data[XLEN-1:1], 1'b0}; // RULE_14
            tmode_d = rf_rd_data[0]; // RULE_13
            tmis_d  = !rf_rd_data[0] && rf_rd_data[1]; // RULE_15
          end
          if (no_delay) begin
            redir_d.valid  = 1'b1; // RULE_11 RULE_12
            redir_d.target = {rf_rd_data[XLEN-1:1], 1'b0};
            redir_d.mode   = rf_rd_data[0];
            mode_d         = rf_rd_data[0];
            tmis_d         = !rf_rd_data[0] && rf_rd_data[1];
            chk_d          = 1'b1;
          end else begin
            st_d = ST_SLOT; // RULE_06 RULE_09 RULE_10
          end
        end
      end
      ST_SLOT: begin
        if (issue_valid) begin
          // a jump in the slot is undefined; flag it and finish the first
          if (ctrl_en_q && (reg_jump || x_jump)) begin
            ev_set[EV_HAZ] = 1'b1; // RULE_07 RULE_17
          end
          redir_d.valid  = 1'b1; // RULE_06
          redir_d.target = tgt_q;
          redir_d.mode   = tmode_q;
          mode_d         = tmode_q; // RULE_05 RULE_13
          chk_d          = 1'b1;
          st_d           = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= ST_IDLE;
      tgt_q   <= '0;
      tmode_q <= MODE_RESET;
      tmis_q  <= 1'b0;
      mode_q  <= MODE_RESET;
      chk_q   <= 1'b0;
      aerr_q  <= 1'b0;
      redir_q <= '0;
      link_q  <= '0;
    end else begin
      st_q    <= st_d;
      tgt_q   <= tgt_d;
      tmode_q <= tmode_d;
      tmis_q  <= tmis_d;
      mode_q  <= mode_d;
      chk_q   <= chk_d;
      aerr_q  <= aerr_d;
      redir_q <= redir_d;
      link_q  <= link_d;
    end
  end

  assign redirect                   = redir_q;
  assign link_wr                    = link_q;
  assign addr_error                 = aerr_q;
  assign instruction_set_select_bit = mode_q;
  assign irq                        = |(ev_q & mask_q);

  // axi4-lite slave
  logic            wr_fire;
  logic            ar_fire;
  logic [EVW-1:0]  ev_clr;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_fire       = aw_have_q && w_have_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ctrl_en_d = ctrl_en_q;
    mask_d    = mask_q;
    ev_clr    = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (awaddr_q)
        OFS_CTRL: if (wstrb0_q) ctrl_en_d = wdata_q[CTRL_EN_BIT];
        OFS_EVENT: if (wstrb0_q) ev_clr = wdata_q[EVW-1:0];
        OFS_MASK: if (wstrb0_q) mask_d = wdata_q[EVW-1:0];
        OFS_STATUS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      case (s_axi_araddr)
        OFS_CTRL:   rdata_d[CTRL_EN_BIT] = ctrl_en_q;
        OFS_STATUS: rdata_d[3:0] = {tmis_q, chk_q, st_q == ST_SLOT, mode_q};
        OFS_EVENT:  rdata_d[EVW-1:0] = ev_q;
        OFS_MASK:   rdata_d[EVW-1:0] = mask_q;
        default:    rresp_d = RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    ev_d = (ev_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      ctrl_en_q <= CTRL_RESET;
      ev_q      <= '0;
      mask_q    <= MASK_RESET;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_en_q <= ctrl_en_d;
      ev_q      <= ev_d;
      mask_q    <= mask_d;
    end
  end

endmodule : jump_register_and_exchange_unit

`default_nettype wire

// >>> verification/core_side_model.sv
// register file and fetch stage standing behind the jump unit
`timescale 1ns/1ps
`default_nettype none

module core_side_model
  import jrx_pkg::*;
(
  // clock
  input  wire logic            aclk,
  // register read and link write
  input  wire logic [4:0]      rd_idx,
  output logic      [XLEN-1:0] rd_data,
  input  wire link_s           link_wr,
  // redirect and fetch
  input  wire redirect_s       redirect,
  output logic                 fetch_valid
);
  logic [XLEN-1:0] regs [32];

  // register 0 is hard zero, as in the real file
  assign rd_data = (rd_idx == 5'h00) ? '0 : regs[rd_idx];

  always @(posedge aclk) begin
    if (link_wr.en) begin
      regs[link_wr.idx] <= link_wr.data;
    end
    // the new target is fetched right after each redirect
    fetch_valid <= redirect.valid;
  end
endmodule : core_side_model

`default_nettype wire

// >>> verification/jump_unit_asserts.sv
// port assertions for the jump unit
`timescale 1ns/1ps
`default_nettype none

module jump_unit_asserts
  import jrx_pkg::*;
(
  // clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // issue and register file
  input wire logic            issue_valid,
  input wire logic [XLEN-1:0] issue_word,
  input wire logic [XLEN-1:0] issue_pc,
  input wire logic            fetch_valid,
  input wire logic [4:0]      rf_rd_idx,
  input wire logic [XLEN-1:0] rf_rd_data,
  // results
  input wire redirect_s       redirect,
  input wire link_s           link_wr,
  input wire logic            addr_error,
  input wire logic            instruction_set_select_bit,
  input wire logic            irq
);
  logic [XLEN-1:0]   pc8_q, src_q, src2_q;
  logic [X_IDX_HI:0] idx_q, idx2_q;
  logic [3:0]        hi_q;
  logic              rj;

  // compact register jump the unit has to act on
  assign rj = issue_valid && instruction_set_select_bit
    && issue_word[OPC_HI:OPC_LO] == REGISTER_FORMAT_OPCODE
    && issue_word[FN_HI:FN_LO] == RJ_FUNCTION && !issue_word[LNK_BIT]
    && (!issue_word[RET_SEL_BIT] || issue_word[RX_HI:RX_LO] == RX_RET_ONLY);

  always_ff @(posedge aclk) begin
    pc8_q  <= issue_pc + LINK_OFFSET;
    src_q  <= rf_rd_data;
    src2_q <= src_q;
    idx_q  <= issue_word[X_IDX_HI:0];
    idx2_q <= idx_q;
    hi_q   <= issue_pc[XLEN-1:REGION_LO];
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_link_value: assert property (link_wr.en |->
    link_wr.idx == LINK_REG && link_wr.data[31:1] == pc8_q[31:1])
    else $error("link value wrong");
  chk_link_mode: assert property (link_wr.en |->
    link_wr.data[0] == $past(instruction_set_select_bit))
    else $error("link mode bit wrong");
  chk_slot_first: assert property (link_wr.en |-> !redirect.valid)
    else $error("redirect before slot");
  chk_exch_target: assert property (link_wr.en && issue_valid |=>
    redirect.valid && redirect.target == {hi_q, idx2_q, IDX_PAD})
    else $error("exchange target wrong");
  chk_exch_flip: assert property (link_wr.en && issue_valid |=>
    redirect.mode != $past(instruction_set_select_bit))
    else $error("exchange mode not inverted");
  chk_mode_load: assert property (redirect.valid |=>
    instruction_set_select_bit == $past(redirect.mode))
    else $error("mode bit not loaded");
  chk_now_jump: assert property (rj && issue_word[NO_DELAY_BIT] |=>
    redirect.valid && redirect.target == {src_q[31:1], 1'b0}
    && redirect.mode == src_q[0]) else $error("immediate jump wrong");
  chk_slot_jump: assert property (rj && !issue_word[NO_DELAY_BIT] ##1 issue_valid
    |-> !redirect.valid ##1 redirect.valid
    && redirect.target == {src2_q[31:1], 1'b0}) else $error("delayed jump wrong");
  chk_read_index: assert property (rj |-> rf_rd_idx == (issue_word[RET_SEL_BIT]
    ? LINK_REG : issue_word[RX_HI:RX_LO] < RX_HIGH_LIMIT
    ? {RX_HIGH_BASE, issue_word[RX_LO]} : {RX_LOW_BASE, issue_word[RX_HI:RX_LO]}))
    else $error("source index wrong");
  chk_fault_fetch: assert property (addr_error |->
    $past(fetch_valid) && !$past(redirect.valid)) else $error("fault not at fetch");

  cov_link: cover property (link_wr.en);
  cov_fault: cover property (addr_error);
  cov_irq: cover property (irq);
endmodule : jump_unit_asserts

bind jump_register_and_exchange_unit jump_unit_asserts jump_unit_asserts_i (.*);

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the jump unit
`timescale 1ns/1ps
`default_nettype none

module tb;
  import jrx_pkg::*;
  logic aclk, aresetn, issue_valid, fetch_valid, addr_error, irq;
  logic instruction_set_select_bit;
  logic [XLEN-1:0] issue_word, issue_pc, rf_rd_data, s_axi_wdata, s_axi_rdata;
  logic [4:0] rf_rd_idx;
  logic [3:0] s_axi_wstrb;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  redirect_s redirect, red;
  link_s link_wr, lnk;
  int n_errors, checks, n_red, n_lnk, n_aerr;
  time t_iss, t_red;
  logic [15:0] tw [9] = '{16'hE820, 16'hE800, 16'hE900, 16'hEB00, 16'hE8A0,
                          16'hEF80, 16'hE840, 16'hE920, 16'hEA80};
  int ix [9] = '{31, 16, 17, 3, 31, 7, 16, 17, 2};
  int tn [9] = '{1, 1, 1, 1, 1, 1, 0, 0, 1};
  logic [31:0] tv [9] = '{32'h2000_0011, 32'h3000_0031, 32'h3000_0045,
    32'h3000_0101, 32'h2000_0011, 32'h3000_0201, 32'h3000_0031,
    32'h3000_0045, 32'h4000_0002};

  jump_register_and_exchange_unit jump_register_and_exchange_unit_i (.*);
  core_side_model core_side_model_i (.aclk(aclk), .rd_idx(rf_rd_idx),
    .rd_data(rf_rd_data), .link_wr(link_wr), .redirect(redirect),
    .fetch_valid(fetch_valid));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (redirect.valid) begin
      n_red++;
      red = redirect;
      t_red = $time;
    end
    if (link_wr.en) begin
      n_lnk++;
      lnk = link_wr;
    end
    if (addr_error) n_aerr++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic axw(input logic [AW-1:0] a, input logic [31:0] v);
    logic ta, tk;
    ta = 1'b0;
    tk = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tk)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) ta = 1'b1;
      if (s_axi_wvalid && s_axi_wready) tk = 1'b1;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tk) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [AW-1:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic iss(input logic [31:0] w, input logic [31:0] pc);
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue_word <= w;
    issue_pc <= pc;
  endtask : iss

  // drop the issue strobe and let results land
  task automatic settle;
    @(posedge aclk);
    issue_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : settle

  task automatic end_sim;
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial begin
    #50000;
    n_errors++;
    end_sim();
  end

  initial begin
    {aresetn, issue_valid, issue_word, issue_pc} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_CTRL);
    chk("ctrl", 32'h1, d);
    axr(OFS_MASK);
    chk("mask_rst", 32'h0, d);
    axr(OFS_STATUS);
    chk("status_rst", 32'h0, d);
    axr(8'h40);
    chk("rd_resp", 32'(RESP_SLVERR), 32'(r));
    axw(8'h40, 32'h1);
    chk("wr_resp", 32'(RESP_SLVERR), 32'(r));
    axw(OFS_MASK, 32'hF);
    axr(OFS_MASK);
    chk("mask", 32'hF, d);
    // last word of a region, with a jump wrongly placed in its slot
    iss({XJ_OPCODE, 26'h0000123}, 32'h0FFF_FFFC);
    t_iss = $time;
    iss({XJ_OPCODE, 26'h0000456}, 32'h1000_0000);
    settle();
    chk("link_n", 32'h1, 32'(n_lnk));
    chk("link_idx", 32'h1F, 32'(lnk.idx));
    chk("link_data", 32'h1000_0004, lnk.data);
    chk("red_n", 32'h1, 32'(n_red));
    chk("red_tgt", 32'h1000_048C, red.target);
    chk("red_lat", 32'h3, 32'((t_red - t_iss) / 10));
    chk("mode", 32'h1, 32'(instruction_set_select_bit));
    axr(OFS_EVENT);
    chk("ev_xchg", 32'hA, d & 32'hA);
    chk("irq_set", 32'h1, 32'(irq));
    axw(OFS_EVENT, 32'hF);
    axr(OFS_EVENT);
    chk("ev_clr", 32'h0, d);
    chk("irq_clr", 32'h0, 32'(irq));
    for (int i = 0; i < 9; i++) begin
      core_side_model_i.regs[ix[i]] = tv[i];
      n_red = 0;
      n_lnk = 0;
      iss({16'h0000, tw[i]}, 32'h2000_0100);
      t_iss = $time;
      if (!tw[i][NO_DELAY_BIT]) iss(32'h0, 32'h2000_0102);
      settle();
      chk("tbl_n", 32'(tn[i]), 32'(n_red));
      chk("tbl_link", 32'h0, 32'(n_lnk));
      if (tn[i] != 0) begin
        chk("tbl_tgt", {tv[i][31:1], 1'b0}, red.target);
        chk("tbl_mode", 32'(tv[i][0]), 32'(red.mode));
        chk("tbl_lat", tw[i][NO_DELAY_BIT] ? 32'h2 : 32'h3,
          32'((t_red - t_iss) / 10));
      end
    end
    chk("aerr_n", 32'h1, 32'(n_aerr));
    axr(OFS_EVENT);
    chk("ev_addr", 32'h4, d & 32'h4);
    chk("irq_on", 32'h1, 32'(irq));
    axw(OFS_MASK, 32'h0);
    chk("irq_mask", 32'h0, 32'(irq));
    // with the unit disabled an exchange jump must leave no trace
    axw(OFS_CTRL, 32'h0);
    axr(OFS_CTRL);
    chk("ctrl_off", 32'h0, d);
    n_lnk = 0;
    n_red = 0;
    iss({XJ_OPCODE, 26'h0000001}, 32'h0000_0100);
    iss(32'h0, 32'h0000_0104);
    settle();
    chk("off_link", 32'h0, 32'(n_lnk));
    chk("off_red", 32'h0, 32'(n_red));
    chk("off_mode", 32'h0, 32'(instruction_set_select_bit));
    end_sim();
  end
endmodule : tb

`default_nettype wire
